// ===== include/bvc_pkg.sv
package bvc_pkg;
	// register location and reset image
	localparam logic [7:0] BVC_ADDR        = 8'h18;
	localparam logic [7:0] BVC_RESET_VAL   = 8'h98;
	// field positions
	localparam int         BVC_PSKIP_BIT   = 7;
	localparam int         BVC_RSVD_BIT    = 6;
	localparam int         BVC_VCODE_MSB   = 5;
	localparam logic [7:0] BVC_WRITE_MASK  = 8'hbf;
	// voltage table anchors, millivolts
	localparam logic [5:0]  BVC_FINE_LAST   = 6'h1a;
	localparam logic [11:0] BVC_FINE_BASE   = 12'h384;
	localparam logic [11:0] BVC_FINE_STEP   = 12'h019;
	localparam logic [11:0] BVC_COARSE_BASE = 12'h640;
	localparam logic [11:0] BVC_COARSE_STEP = 12'h032;
	localparam logic [5:0]  BVC_CODE_1C     = 6'h1c;
	localparam logic [5:0]  BVC_CODE_1D     = 6'h1d;
	localparam logic [11:0] BVC_MV_1C       = 12'h672;
	localparam logic [11:0] BVC_MV_1D       = 12'h6d6;
	// blanking time
	localparam int         BVC_CLK_HZ      = 20000000;
	localparam int         BVC_BLANK_MS    = 5;
	localparam int         BVC_BLANK_CYC   = BVC_BLANK_MS * (BVC_CLK_HZ / 1000);
	// register-side write request
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} bvc_wr_type;
endpackage

// ===== logic/bvc_vdecode.sv
`timescale 1ns/100ps
module bvc_vdecode
	import bvc_pkg::*;
(
	// code in, millivolts out
	input  wire logic [5:0]  code,
	output logic      [11:0] millivolt
);
	// coarse segment grows off 1.600 V, two printed codes override it
	always_comb begin
		if (code <= BVC_FINE_LAST) begin
			millivolt = BVC_FINE_BASE + 12'(code) * BVC_FINE_STEP;
		end else if (code == BVC_CODE_1C) begin
			millivolt = BVC_MV_1C;
		end else if (code == BVC_CODE_1D) begin
			millivolt = BVC_MV_1D;
		end else begin
			millivolt = BVC_COARSE_BASE + 12'(code - 6'h1b) * BVC_COARSE_STEP;
		end
	end
endmodule

// ===== logic/bvc_reg.sv
`timescale 1ns/100ps
module bvc_reg
	import bvc_pkg::*;
#(
	parameter int BLANK_CYC = BVC_BLANK_CYC
)(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// register access from the serial front end
	input  wire bvc_pkg::bvc_wr_type wr,
	input  wire logic [7:0]        rd_addr,
	output logic      [7:0]        rd_data,
	// unlock state and power-up default
	input  wire logic              unlock_ok,
	input  wire logic              default_load,
	input  wire logic [7:0]        default_val,
	// converter controls
	output logic                   pulse_skip_enable,
	output logic      [5:0]        vcode,
	output logic      [11:0]       vout_mv,
	output logic                   monitor_blank
);
	import bvc_pkg::*;

	logic [7:0]  reg_q;
	logic [22:0] blank_q;
	logic        hit;
	logic        wr_ok;

	assign hit   = wr.valid && (wr.addr == BVC_ADDR);
	assign wr_ok = hit && unlock_ok;

	// register storage; strap-style default loads after reset release
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_q <= BVC_RESET_VAL;
		end else if (default_load) begin
			reg_q <= default_val & BVC_WRITE_MASK;
		end else if (wr_ok) begin
			reg_q <= wr.data & BVC_WRITE_MASK;
		end
	end

	// blanking counter; a locked-out write still counts as a write attempt on the bus, so it blanks too
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			blank_q <= 23'h0;
		end else if (hit) begin
			blank_q <= 23'(BLANK_CYC);
		end else if (blank_q != 23'h0) begin
			blank_q <= blank_q - 23'h1;
		end
	end

	assign monitor_blank     = (blank_q != 23'h0);
	assign pulse_skip_enable = reg_q[BVC_PSKIP_BIT];
	assign vcode             = reg_q[BVC_VCODE_MSB:0];
	assign rd_data           = (rd_addr == BVC_ADDR) ? reg_q : 8'h00;

	// table decode; 1Dh stays at printed value
	bvc_vdecode u_dec (
		.code      (vcode),
		.millivolt (vout_mv)
	);

	AST_RSVD: assert property (@(posedge mclk) disable iff (sys_rst) !reg_q[BVC_RSVD_BIT])
		else $error("reserved bit set");
	AST_LOCK: assert property (@(posedge mclk) disable iff (sys_rst)
		(hit && !unlock_ok && !default_load) |=> reg_q == $past(reg_q))
		else $error("locked write changed register");
	AST_WR: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_ok && !default_load) |=> reg_q == ($past(wr.data) & BVC_WRITE_MASK))
		else $error("unlocked write lost");
	AST_BLANK: assert property (@(posedge mclk) disable iff (sys_rst)
		hit |=> monitor_blank [*8])
		else $error("blanking not held");
	AST_BLANK_END: assert property (@(posedge mclk) disable iff (sys_rst)
		(blank_q == 23'h1 && !hit) |=> !monitor_blank)
		else $error("blanking overran");
	AST_V18: assert property (@(posedge mclk) disable iff (sys_rst)
		vcode == 6'h18 |-> vout_mv == 12'd1500)
		else $error("18h not 1.500 V");
	AST_VFINE: assert property (@(posedge mclk) disable iff (sys_rst)
		vcode == 6'h1a |-> vout_mv == 12'd1550)
		else $error("1Ah not 1.550 V");
	AST_VTOP: assert property (@(posedge mclk) disable iff (sys_rst)
		vcode == 6'h3f |-> vout_mv == 12'd3400)
		else $error("3Fh not 3.400 V");
	AST_V1D: assert property (@(posedge mclk) disable iff (sys_rst)
		vcode == 6'h1d |-> vout_mv == 12'd1750)
		else $error("1Dh not 1.750 V");
	AST_PSKIP: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_ok && !default_load) |=> pulse_skip_enable == $past(wr.data[7]))
		else $error("pulse skip not written");
endmodule

// ===== verification/bvc_host.sv
`timescale 1ns/100ps
// host side: one-cycle write pulses, call just after a rising edge
module bvc_host
	import bvc_pkg::*;
(
	// clock and request
	mclk,
	wr
);
	input  wire logic          mclk;
	output bvc_pkg::bvc_wr_type wr;
	initial wr = '0;
	// released fields flip so a stale address never looks valid
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		wr <= '{1'b1, a, d};
		@(posedge mclk);
		wr <= '{1'b0, ~a, ~d};
	endtask
endmodule

// ===== verification/buck3_voltage_control_register_tb.sv
`timescale 1ns/100ps
module buck3_voltage_control_register_tb;
	import bvc_pkg::*;
	logic       mclk, sys_rst, unlock_ok, ld, pskip, blank;
	logic [7:0] rd_addr, dval, rd_data;
	logic [5:0] vcode;
	logic [11:0] mv_o;
	bvc_wr_type wr;
	int         num_errors = 0;
	int         checks = 0;
	bvc_host host (.mclk(mclk), .wr(wr));
	bvc_reg #(.BLANK_CYC(20)) DUT (.mclk(mclk), .sys_rst(sys_rst), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
		.unlock_ok(unlock_ok), .default_load(ld), .default_val(dval), .pulse_skip_enable(pskip),
		.vcode(vcode), .vout_mv(mv_o), .monitor_blank(blank));
	// wide enough for the packed status words, so no field is cut off
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// expected millivolts, 1dh kept at the printed value
	function automatic logic [11:0] mv(input logic [5:0] c);
		if (c <= 6'h1a) return 12'h384 + 12'h019 * c;
		return (c == 6'h1d) ? 12'h6d6 : 12'h640 + 12'h032 * (c - 6'h1b);
	endfunction
	task automatic t_reset;
		@(negedge mclk);
		chk({pskip, blank, vcode, rd_data}, {2'b10, 6'h18, 8'h98});
		chk(mv_o, 12'h5dc);
		@(posedge mclk);
		rd_addr <= 8'h19;
		@(negedge mclk);
		chk(rd_data, 8'h00);
		$display("reset done");
	endtask
	task automatic t_write;
		@(posedge mclk);
		rd_addr <= 8'h18;
		host.put(8'h18, 8'h55);
		@(negedge mclk);
		chk({pskip, vcode, blank, rd_data}, {1'b0, 6'h15, 1'b1, 8'h15});
		// blanking stands exactly 20 cycles in this run, last high then first low
		repeat (19) @(negedge mclk);
		chk(blank, 1'b1);
		repeat (1) @(negedge mclk);
		chk(blank, 1'b0);
		$display("write done");
	endtask
	// every code, bit 6 set on the way in
	task automatic t_sweep;
		for (int c = 0; c < 64; c++) begin
			@(posedge mclk);
			host.put(8'h18, {2'b01, c[5:0]});
			@(negedge mclk);
			chk(mv_o, mv(c[5:0]));
			chk(rd_data, {2'b00, c[5:0]});
		end
		$display("sweep done");
	endtask
	task automatic t_lock_def;
		repeat (30) @(posedge mclk);
		unlock_ok <= 1'b0;
		host.put(8'h18, 8'h80);
		@(negedge mclk);
		chk({rd_data, blank}, {8'h3f, 1'b1});
		@(posedge mclk);
		unlock_ok <= 1'b1;
		ld <= 1'b1;
		host.put(8'h18, 8'h00);
		ld <= 1'b0;
		@(negedge mclk);
		chk({pskip, rd_data}, {1'b1, 8'hbf});
		$display("lock and default done");
	endtask
	// reset in mid-run must restore the reset image and drop blanking
	task automatic t_rerst;
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(negedge mclk);
		chk({pskip, blank, vcode, rd_data}, {2'b10, 6'h18, 8'h98});
		chk(mv_o, 12'h5dc);
		$display("mid-run reset done");
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// whole run is a few hundred cycles
	initial begin
		#100000;
		num_errors++;
		wrap_up;
	end
	initial begin
		sys_rst = 1'b1;
		unlock_ok = 1'b1;
		ld = 1'b0;
		dval = 8'hff;
		rd_addr = 8'h18;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset;
		t_write;
		t_sweep;
		t_lock_def;
		t_rerst;
		wrap_up;
	end
endmodule
